// ### dv/fsrp_host_bfm.sv
// host bus model issuing flash reads and instruction byte writes
`timescale 1ns/1ps
module fsrp_host_bfm (
  input wire logic core_clk,
  output logic busRd,
  output logic [3:0] busAddr,
  output logic main_sector_select,
  output logic boot_sector_select,
  output logic instrWr,
  output logic [1:0] instrKind,
  output logic [2:0] instrPos,
  output logic [3:0] instrAddr,
  output logic [7:0] instrData,
  output logic eraseProtected,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  // ----------------------------------------------------------
  // idle values at time zero
  // ----------------------------------------------------------
  initial begin
    busRd = 1'b0;
    busAddr = 4'h0;
    main_sector_select = 1'b0;
    boot_sector_select = 1'b0;
    instrWr = 1'b0;
    instrKind = 2'h0;
    instrPos = 3'h0;
    instrAddr = 4'h0;
    instrData = 8'h00;
    eraseProtected = 1'b0;
  end

  // ----------------------------------------------------------
  // bus tasks, all driven at the falling edge
  // ----------------------------------------------------------
  // select held as a level across a whole polling session
  task automatic sel(input logic [1:0] s);
    @(negedge core_clk);
    main_sector_select = s[0];
    boot_sector_select = s[1];
  endtask

  // one read cycle, answer taken one edge after the request
  task automatic rd(input logic [3:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge core_clk);
    busRd = 1'b1;
    busAddr = a;
    @(negedge core_clk);
    d = rdData;
    v = rdValid;
    busRd = 1'b0;
    busAddr = ~a; // stale address must not be relied on
  endtask

  // one instruction byte write
  task automatic wr(input logic [1:0] k, input logic [2:0] p,
                    input logic [3:0] a, input logic [7:0] x,
                    input logic prot);
    @(negedge core_clk);
    instrWr = 1'b1;
    instrKind = k;
    instrPos = p;
    instrAddr = a;
    instrData = x;
    eraseProtected = prot;
    @(negedge core_clk);
    instrWr = 1'b0;
    instrData = ~x;
    eraseProtected = ~prot;
  endtask
endmodule

// ### dv/tb_top.sv
// self-checking bench for the flash read and status polling block
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] P_CYC = 16'h0010;
  localparam logic [15:0] E_CYC = 16'h0014;
  localparam logic [15:0] R_CYC = 16'h0012;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic busRd, mainSel, bootSel, instrWr, eraseProt, rdValid, opBusy;
  logic [3:0] busAddr, instrAddr, a;
  logic [1:0] instrKind;
  logic [2:0] instrPos;
  logic [7:0] instrData, rdData, d, x;
  logic v;
  logic [7:0] mem [16];
  int failures = 0;
  int total_checks = 0;
  int seed = 37699;
  int cyc = 0;

  // ----------------------------------------------------------
  // clock and cycle count
  // ----------------------------------------------------------
  always #2 core_clk = ~core_clk;

  // cycle counter for operation lengths
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
  end

  // ----------------------------------------------------------
  // design and host
  // ----------------------------------------------------------
  fsrp_flash_read #(
    .PROG_CYC(P_CYC),
    .ERASE_CYC(E_CYC),
    .PROT_CYC(R_CYC)
  ) u_dut (
    .core_clk(core_clk),
    .rst(rst),
    .busRd(busRd),
    .busAddr(busAddr),
    .main_sector_select(mainSel),
    .boot_sector_select(bootSel),
    .instrWr(instrWr),
    .instrKind(instrKind),
    .instrPos(instrPos),
    .instrAddr(instrAddr),
    .instrData(instrData),
    .eraseProtected(eraseProt),
    .rdData(rdData),
    .rdValid(rdValid),
    .opBusy(opBusy)
  );

  fsrp_host_bfm u_host (
    .core_clk(core_clk),
    .busRd(busRd),
    .busAddr(busAddr),
    .main_sector_select(mainSel),
    .boot_sector_select(bootSel),
    .instrWr(instrWr),
    .instrKind(instrKind),
    .instrPos(instrPos),
    .instrAddr(instrAddr),
    .instrData(instrData),
    .eraseProtected(eraseProt),
    .rdData(rdData),
    .rdValid(rdValid)
  );

  // ----------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // read one byte and compare it with the model
  task automatic rdExp(input logic [3:0] ad, input logic [7:0] exp);
    u_host.rd(ad, d, v);
    chkBit(v, 1'b1);
    chkByte(d, exp);
  endtask

  // launch an operation, poll status, then check the outcome
  task automatic op(input logic [1:0] k, input logic [3:0] ad,
                    input logic [7:0] xd, input logic prot,
                    input int dur);
    int t0;
    logic tg;
    logic [7:0] st;
    tg = 1'b0;
    u_host.wr(k, (k == 2'h1) ? 3'h4 : 3'h6, ad, xd, prot);
    t0 = cyc;
    chkBit(opBusy, 1'b1);
    repeat (4) begin
      st = (k == 2'h1) ? {~xd[7], tg, 6'h00} : 8'h00;
      rdExp(4'($random(seed)), st);
      tg = ~tg;
    end
    while (opBusy === 1'b1 && cyc - t0 < 1000) begin
      @(negedge core_clk);
    end
    chkBit(cyc - t0 >= dur && cyc - t0 <= dur + 2, 1'b1);
    if (k == 2'h1) begin
      mem[ad] = xd;
    end else if (!prot) begin
      foreach (mem[i]) mem[i] = 8'hff;
    end
    rdExp(ad, mem[ad]);
  endtask

  // ----------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    test_done();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    foreach (mem[i]) mem[i] = 8'hff;
    u_host.sel(2'b01);
    for (int i = 0; i < 16; i++) begin
      rdExp(4'(i), 8'hff);
    end
    u_host.sel(2'b00);
    u_host.rd(4'h3, d, v);
    chkBit(v, 1'b0);
    u_host.sel(2'b10);
    u_host.wr(2'h1, 3'h3, 4'h5, 8'h12, 1'b0);
    chkBit(opBusy, 1'b0);
    for (int i = 0; i < 4; i++) begin
      x = 8'($random(seed));
      x[7] = i[0];
      a = 4'($random(seed));
      op(2'h1, a, x, 1'b0, P_CYC);
    end
    u_host.sel(2'b01);
    op(2'h2, a, 8'h00, 1'b1, R_CYC);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    foreach (mem[i]) mem[i] = 8'hff;
    rdExp(a, 8'hff);
    op(2'h1, a, 8'h3c, 1'b0, P_CYC);
    op(2'h2, 4'h0, 8'h00, 1'b0, E_CYC);
    u_host.wr(2'h1, 3'h4, 4'h9, 8'h00, 1'b0);
    u_host.wr(2'h3, 3'h1, 4'h0, 8'h00, 1'b0);
    @(negedge core_clk);
    chkBit(opBusy, 1'b0);
    rdExp(4'h9, mem[9]);
    test_done();
  end
endmodule

// ### verilog/fsrp_array.sv
// flip-flop storage for the flash array contents
`timescale 1ns/1ps
module fsrp_array (
  input wire logic core_clk,
  input wire logic rst,
  fsrp_core_if.mem core
);

  typedef struct packed {
    logic [15:0][7:0] mem;
  } fsrp_arr_state_t;

  fsrp_arr_state_t s_r;
  fsrp_arr_state_t s_nxt;

  // ------------------------------------------------------------
  // storage update
  // ------------------------------------------------------------
  // erase fills every byte, a program writes one byte
  always_comb begin
    s_nxt = s_r;
    if (core.eraseAll) begin
      for (int i = 0; i < fsrp_pkg::ARR_DEPTH; i++) begin
        s_nxt.mem[i] = fsrp_pkg::ERASED_BYTE;
      end
    end else if (core.wrEn) begin
      s_nxt.mem[core.wrIdx] = core.wrData;
    end
  end

  // power-up contents are the erased state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= {fsrp_pkg::ARR_DEPTH{fsrp_pkg::ERASED_BYTE}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign core.rdByte = s_r.mem[core.rdIdx];

endmodule

// ### verilog/fsrp_core_if.sv
// links between the sequencer, the storage array and the timer
`timescale 1ns/1ps
interface fsrp_core_if;
  logic wrEn;
  logic [3:0] wrIdx;
  logic [7:0] wrData;
  logic eraseAll;
  logic [3:0] rdIdx;
  logic [7:0] rdByte;
  logic tmrLoad;
  logic [15:0] tmrCount;
  logic tmrDone;

  modport ctrl (
    output wrEn,
    output wrIdx,
    output wrData,
    output eraseAll,
    output rdIdx,
    input rdByte,
    output tmrLoad,
    output tmrCount,
    input tmrDone
  );
  modport mem (
    input wrEn,
    input wrIdx,
    input wrData,
    input eraseAll,
    input rdIdx,
    output rdByte
  );
  modport tmr (
    input tmrLoad,
    input tmrCount,
    output tmrDone
  );
endinterface

// ### verilog/fsrp_flash_read.sv
// flash read path: array reads, data polling and toggle status
//
// Behaviour
// [RQ1] read-array mode after reset and after the reset-flash instruction
// [RQ2] in read-array mode host reads return stored array bytes
// [RQ3] whenever no program or erase runs, the array is in read-array mode
// [RQ4] status reads answered repeatedly for as long as an operation runs
// [RQ5] while programming, polling bit reads inverse of data bit 7
// [RQ6] after programming, polling bit equals bit 7 of programmed byte
// [RQ7] host keeps a sector select asserted during the whole polling
// [RQ8] polling bit reads 0 during erase and 1 once erase completes
// [RQ9] flag valid after fourth program write or sixth erase write
// [RQ10] fully protected erase: bit 0 for 100 us, no erasure, then data
// [RQ11] toggle bit inverts on every status read while programming
// [RQ12] after programming toggling stops and real byte contents are read
// [RQ13] polling on data bit 7, toggle on bit 6, other bits zero
`timescale 1ns/1ps
module fsrp_flash_read #(
  parameter logic [15:0] PROG_CYC = fsrp_pkg::PROG_CYC,
  parameter logic [15:0] ERASE_CYC = fsrp_pkg::ERASE_CYC,
  parameter logic [15:0] PROT_CYC = fsrp_pkg::PROT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic busRd,
  input wire logic [3:0] busAddr,
  input wire logic main_sector_select,
  input wire logic boot_sector_select,
  input wire logic instrWr,
  input wire logic [1:0] instrKind,
  input wire logic [2:0] instrPos,
  input wire logic [3:0] instrAddr,
  input wire logic [7:0] instrData,
  input wire logic eraseProtected,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic opBusy
);

  typedef struct packed {
    fsrp_pkg::fsrp_mode_t mode;
    logic toggle;
    logic [3:0] progIdx;
    logic [7:0] progData;
    logic [7:0] rdData;
    logic rdValid;
    logic busy;
    logic wrEn;
    logic eraseAll;
    logic tmrLoad;
    logic [15:0] tmrCount;
  } fsrp_state_t;

  fsrp_state_t s_r;
  fsrp_state_t s_nxt;
  fsrp_core_if core ();
  logic selActive;
  logic hostRead;

  // ------------------------------------------------------------
  // leaf instances
  // ------------------------------------------------------------
  fsrp_array u_array (
    .core_clk(core_clk),
    .rst(rst),
    .core(core.mem)
  );

  fsrp_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .core(core.tmr)
  );

  // storage and timer controls follow the next state so a write
  // lands on the same edge as the return to read-array mode
  assign core.wrEn = s_nxt.wrEn;
  assign core.wrIdx = s_nxt.progIdx;
  assign core.wrData = s_nxt.progData;
  assign core.eraseAll = s_nxt.eraseAll;
  assign core.tmrLoad = s_nxt.tmrLoad;
  assign core.tmrCount = s_nxt.tmrCount;
  assign core.rdIdx = busAddr;

  // a read counts only with one of the sector selects active
  assign selActive = main_sector_select | boot_sector_select; // RQ7
  assign hostRead = busRd & selActive;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // completion first, then instruction writes, then the read answer
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdValid = 1'b0;
    s_nxt.wrEn = 1'b0;
    s_nxt.eraseAll = 1'b0;
    s_nxt.tmrLoad = 1'b0;
    // end of an operation returns to read-array mode
    if (core.tmrDone) begin
      case (s_r.mode)
        fsrp_pkg::FSRP_PROGRAM: begin
          s_nxt.wrEn = 1'b1; // RQ6
          s_nxt.mode = fsrp_pkg::FSRP_READ_ARRAY; // RQ3
        end
        fsrp_pkg::FSRP_ERASE: begin
          s_nxt.eraseAll = 1'b1; // RQ8
          s_nxt.mode = fsrp_pkg::FSRP_READ_ARRAY; // RQ3
        end
        fsrp_pkg::FSRP_PROTECTED: begin
          s_nxt.mode = fsrp_pkg::FSRP_READ_ARRAY; // RQ10
        end
        default: begin
          s_nxt.mode = s_r.mode;
        end
      endcase
    end
    // instruction writes launch or abort operations
    if (instrWr) begin
      case (fsrp_pkg::fsrp_cmd_t'(instrKind))
        fsrp_pkg::FSRP_CMD_PROG: begin
          if (instrPos == fsrp_pkg::PROG_LAUNCH_POS &&
              s_nxt.mode == fsrp_pkg::FSRP_READ_ARRAY) begin
            s_nxt.mode = fsrp_pkg::FSRP_PROGRAM; // RQ9
            s_nxt.progIdx = instrAddr;
            s_nxt.progData = instrData;
            s_nxt.toggle = 1'b0;
            s_nxt.tmrLoad = 1'b1;
            s_nxt.tmrCount = PROG_CYC;
          end
        end
        fsrp_pkg::FSRP_CMD_ERASE: begin
          if (instrPos == fsrp_pkg::ERASE_LAUNCH_POS &&
              s_nxt.mode == fsrp_pkg::FSRP_READ_ARRAY) begin
            s_nxt.tmrLoad = 1'b1;
            if (eraseProtected) begin
              s_nxt.mode = fsrp_pkg::FSRP_PROTECTED; // RQ10
              s_nxt.tmrCount = PROT_CYC; // RQ10
            end else begin
              s_nxt.mode = fsrp_pkg::FSRP_ERASE; // RQ9
              s_nxt.tmrCount = ERASE_CYC;
            end
          end
        end
        fsrp_pkg::FSRP_CMD_RESET: begin
          s_nxt.mode = fsrp_pkg::FSRP_READ_ARRAY; // RQ1
          s_nxt.wrEn = 1'b0;
          s_nxt.eraseAll = 1'b0;
        end
        default: begin
          s_nxt.mode = s_nxt.mode;
        end
      endcase
    end
    // read answer follows the mode at the time of the read
    if (hostRead) begin
      s_nxt.rdValid = 1'b1; // RQ4
      case (s_r.mode)
        fsrp_pkg::FSRP_READ_ARRAY: begin
          s_nxt.rdData = core.rdByte; // RQ2
        end
        fsrp_pkg::FSRP_PROGRAM: begin
          s_nxt.rdData = fsrp_pkg::STATUS_BASE; // RQ13
          s_nxt.rdData[fsrp_pkg::POLL_BIT] = ~s_r.progData[7]; // RQ5
          s_nxt.rdData[fsrp_pkg::TOGGLE_BIT] = s_r.toggle; // RQ11
          s_nxt.toggle = ~s_r.toggle; // RQ11
        end
        default: begin
          // erase and protected windows show a cleared polling bit
          s_nxt.rdData = fsrp_pkg::STATUS_BASE; // RQ8 RQ10
        end
      endcase
    end
    s_nxt.busy = (s_nxt.mode != fsrp_pkg::FSRP_READ_ARRAY);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0; // RQ1
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdData = s_r.rdData;
  assign rdValid = s_r.rdValid;
  assign opBusy = s_r.busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_prog_read;
    s_r.mode == fsrp_pkg::FSRP_PROGRAM && hostRead;
  endsequence

  sequence s_prog_finish;
    s_r.mode == fsrp_pkg::FSRP_PROGRAM && core.tmrDone && !instrWr
      ##1 hostRead && !instrWr;
  endsequence

  sequence s_erase_finish;
    s_r.mode == fsrp_pkg::FSRP_ERASE && core.tmrDone && !instrWr
      ##1 hostRead && !instrWr;
  endsequence

  property p_reset_read;
    @(posedge core_clk) rst |=> s_r.mode == fsrp_pkg::FSRP_READ_ARRAY
      && !rdValid && !opBusy;
  endproperty
  a_reset_read: assert property (p_reset_read) // RQ1
    else $error("mode not read-array after reset");

  property p_array_read;
    @(posedge core_clk) disable iff (rst)
      s_r.mode == fsrp_pkg::FSRP_READ_ARRAY && hostRead
      |=> rdValid && rdData == $past(core.rdByte);
  endproperty
  a_array_read: assert property (p_array_read) // RQ2
    else $error("array read returned wrong byte");

  property p_idle_when_free;
    @(posedge core_clk) disable iff (rst)
      !opBusy |-> s_r.mode == fsrp_pkg::FSRP_READ_ARRAY;
  endproperty
  a_idle_when_free: assert property (p_idle_when_free) // RQ3
    else $error("not busy yet outside read-array mode");

  property p_prog_poll;
    @(posedge core_clk) disable iff (rst)
      s_prog_read |=> rdValid
      && rdData[fsrp_pkg::POLL_BIT] == !$past(s_r.progData[7])
      && rdData[5:0] == 6'h00;
  endproperty
  a_prog_poll: assert property (p_prog_poll) // RQ5
    else $error("polling bit not inverse of data bit 7");

  property p_prog_done;
    @(posedge core_clk) disable iff (rst)
      s_prog_finish |=> rdValid && rdData == $past(s_r.progData, 2);
  endproperty
  a_prog_done: assert property (p_prog_done) // RQ6
    else $error("programmed byte not read back after completion");

  property p_erase_zero;
    @(posedge core_clk) disable iff (rst)
      s_r.mode == fsrp_pkg::FSRP_ERASE && hostRead
      |=> rdValid && !rdData[fsrp_pkg::POLL_BIT];
  endproperty
  a_erase_zero: assert property (p_erase_zero) // RQ8
    else $error("polling bit not 0 during erase");

  property p_erase_one;
    @(posedge core_clk) disable iff (rst)
      s_erase_finish |=> rdData[fsrp_pkg::POLL_BIT];
  endproperty
  a_erase_one: assert property (p_erase_one) // RQ8
    else $error("polling bit not 1 after erase");

  property p_launch;
    @(posedge core_clk) disable iff (rst)
      instrWr && !core.tmrDone && s_r.mode == fsrp_pkg::FSRP_READ_ARRAY
      && instrKind == 2'h1 && instrPos == fsrp_pkg::PROG_LAUNCH_POS
      |=> s_r.mode == fsrp_pkg::FSRP_PROGRAM && opBusy;
  endproperty
  a_launch: assert property (p_launch) // RQ9
    else $error("program not started on fourth write");

  property p_protected;
    @(posedge core_clk) disable iff (rst)
      s_r.mode == fsrp_pkg::FSRP_PROTECTED && hostRead
      |=> rdValid && !rdData[fsrp_pkg::POLL_BIT];
  endproperty
  a_protected: assert property (p_protected) // RQ10
    else $error("polling bit not 0 in protected window");

  property p_toggle;
    @(posedge core_clk) disable iff (rst)
      s_prog_read ##1 s_prog_read
      |=> rdData[fsrp_pkg::TOGGLE_BIT] != $past(rdData[fsrp_pkg::TOGGLE_BIT]);
  endproperty
  a_toggle: assert property (p_toggle) // RQ11
    else $error("toggle bit did not invert between reads");

  property p_repeat_status;
    @(posedge core_clk) disable iff (rst)
      opBusy && hostRead [*2] |=> rdValid ##0 $past(rdValid);
  endproperty
  a_repeat_status: assert property (p_repeat_status) // RQ4
    else $error("repeated status read not answered");

endmodule

// ### verilog/fsrp_pkg.sv
// constants and types for the flash read and status polling block
package fsrp_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int ARR_DEPTH = 16;
  localparam int IDX_W = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ------------------------------------------------------------
  // status byte layout
  // ------------------------------------------------------------
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [7:0] STATUS_BASE = 8'h00;

  // ------------------------------------------------------------
  // instruction sequence positions that launch an operation
  // ------------------------------------------------------------
  localparam logic [2:0] PROG_LAUNCH_POS = 3'h4;
  localparam logic [2:0] ERASE_LAUNCH_POS = 3'h6;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int PROG_TIME_NS = 20000;
  localparam int ERASE_TIME_NS = 200000;
  localparam int PROT_TIME_NS = 100000;
  localparam int TMR_W = 16;
  localparam logic [15:0] PROG_CYC = 16'(PROG_TIME_NS * CLK_MHZ / 1000);
  localparam logic [15:0] ERASE_CYC = 16'(ERASE_TIME_NS * CLK_MHZ / 1000);
  localparam logic [15:0] PROT_CYC = 16'(PROT_TIME_NS * CLK_MHZ / 1000);

  // ------------------------------------------------------------
  // instruction kinds and array modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FSRP_CMD_NONE,
    FSRP_CMD_PROG,
    FSRP_CMD_ERASE,
    FSRP_CMD_RESET
  } fsrp_cmd_t;

  typedef enum logic [1:0] {
    FSRP_READ_ARRAY,
    FSRP_PROGRAM,
    FSRP_ERASE,
    FSRP_PROTECTED
  } fsrp_mode_t;

endpackage

// ### verilog/fsrp_timer.sv
// down counter that times program, erase and protected windows
`timescale 1ns/1ps
module fsrp_timer (
  input wire logic core_clk,
  input wire logic rst,
  fsrp_core_if.tmr core
);

  typedef struct packed {
    logic [15:0] count;
    logic done;
  } fsrp_tmr_state_t;

  fsrp_tmr_state_t s_r;
  fsrp_tmr_state_t s_nxt;

  // ------------------------------------------------------------
  // countdown
  // ------------------------------------------------------------
  // done pulses on the edge the count runs out
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (core.tmrLoad) begin
      s_nxt.count = core.tmrCount;
    end else if (s_r.count != 16'h0000) begin
      s_nxt.count = s_r.count - 16'h0001;
      s_nxt.done = (s_r.count == 16'h0001);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign core.tmrDone = s_r.done;

endmodule
